// file: rtg_pkg.sv
package rtg_pkg;
  localparam int CNT_W = 20;
  localparam int CLK_HZ = 20_000_000;
  localparam int MIN_RATE_HZ = 50;
  localparam int MAX_RATE_HZ = 20000;
  localparam int WDOG_TIME_MS = 100;
  localparam int FAKE_RATE_HZ = 250;
  localparam int MAX_PERIOD_CYC = CLK_HZ / MIN_RATE_HZ;
  localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;
  localparam int WDOG_CYC = (CLK_HZ / 1000) * WDOG_TIME_MS;
  localparam int FAKE_CYC = CLK_HZ / FAKE_RATE_HZ;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RDELAY = 8'h08;
  localparam logic [3:0] GRP_CTL = 4'h0;
  localparam logic [3:0] GRP_PERIOD = 4'h1;
  localparam logic [3:0] GRP_GDELAY = 4'h2;
  localparam logic [3:0] GRP_GWIDTH = 4'h3;
  localparam logic [3:0] GRP_MINP = 4'h4;
  localparam logic [3:0] GRP_MAXP = 4'h5;
  localparam int CTRL_W = 12;
  localparam int CTRL_EN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_FALL = 2;
  localparam int CTRL_WSEL = 4;
  localparam int CTRL_POL = 8;
  localparam int ST_NOTRIG = 0;
  localparam int ST_BLANK = 1;
  localparam int ST_TRIG = 4;
  localparam logic [CNT_W-1:0] PERIOD_RST = 20'h04e20;
  localparam logic [CNT_W-1:0] GWIDTH_RST = 20'h00014;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: rtg_edge_sync.sv
`timescale 1ns/1ps
module rtg_edge_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  input  wire logic fall_sel,
  output logic      pulse
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic pulse;
  } rtg_sync_t;
  rtg_sync_t s_reg;
  rtg_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    // only s2/s3 feed the edge compare; s1 may be metastable
    s_next.pulse = fall_sel ? (s_reg.s3 & ~s_reg.s2)
                            : (s_reg.s2 & ~s_reg.s3);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pulse = s_reg.pulse;
endmodule

// file: rtg_gen.sv
`timescale 1ns/1ps
module rtg_gen #(
  parameter int CW = rtg_pkg::CNT_W
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          en,
  input  wire logic          free_run,
  input  wire logic          sync,
  input  wire logic [CW-1:0] period,
  input  wire logic [CW-1:0] delay,
  input  wire logic [CW-1:0] width,
  input  wire logic          pol,
  output logic               trig,
  output logic               start
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          trig;
    logic          start;
  } rtg_gen_t;
  rtg_gen_t s_reg;
  rtg_gen_t s_next;
  logic     act;
  logic     wrap;

  always_comb begin
    s_next = s_reg;
    act = (s_reg.cnt >= delay) &&
          ({1'b0, s_reg.cnt} < ({1'b0, delay} + {1'b0, width}));
    wrap = free_run && (s_reg.cnt >= period - CW'(1));
    s_next.start = 1'b0;
    if (!en) begin
      s_next.cnt = '0;
      s_next.trig = pol;
    end else begin
      // edges only on the sample clock grid
      s_next.trig = act ^ pol;
      if (sync || wrap) begin
        s_next.cnt = '0;
        s_next.start = 1'b1;
      end else if (s_reg.cnt != '1) begin
        // saturates when slaved, so a lost sync never retriggers
        if (free_run || s_reg.cnt < period) begin
          s_next.cnt = s_reg.cnt + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign trig = s_reg.trig;
  assign start = s_reg.start;
endmodule

// file: rtg_top.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module rtg_top #(
  parameter int CW       = rtg_pkg::CNT_W,
  parameter int WDOG_CYC = rtg_pkg::WDOG_CYC,
  parameter int FAKE_CYC = rtg_pkg::FAKE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        first_trigger_connector_i,
  output logic             first_trigger_connector_o,
  output logic             first_trigger_connector_oe,
  output logic             trigger_out_two,
  output logic             trigger_out_three,
  output logic             trigger_out_four,
  output logic             range_zero,
  output logic             data_blank,
  output logic             no_trigger
);
  localparam int WDW = $clog2(WDOG_CYC + 1);
  localparam int FKW = $clog2(FAKE_CYC + 1);

  typedef struct packed {
    logic                       awrdy;
    logic                       wrdy;
    logic                       arrdy;
    logic [7:0]                 aw_addr;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic [rtg_pkg::CTRL_W-1:0] ctrl;
    logic [CW-1:0]              rdelay;
    logic [3:0][CW-1:0]         period;
    logic [3:0][CW-1:0]         gdelay;
    logic [3:0][CW-1:0]         gwidth;
    logic [3:0][CW-1:0]         minp;
    logic [3:0][CW-1:0]         maxp;
    logic [WDW-1:0]             wd;
    logic                       no_trig;
    logic [FKW-1:0]             fake_cnt;
    logic [CW-1:0]              rz_cnt;
    logic                       rz_run;
    logic                       range_zero;
    logic                       oe;
  } rtg_state_t;

  rtg_state_t         s_reg;
  rtg_state_t         s_next;
  logic [3:0]         gtrig;
  logic [3:0]         gstart;
  logic [3:0][CW-1:0] eff_p;
  logic               ext_pulse;
  logic               fake_pulse;
  logic               pretrig;
  logic               en;
  logic               ext;
  logic [1:0]         wsel;
  logic [31:0]        val;
  logic [1:0]         idx;
  logic [1:0]         ridx;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign en = s_reg.ctrl[rtg_pkg::CTRL_EN];
  assign ext = s_reg.ctrl[rtg_pkg::CTRL_EXT];
  assign wsel = s_reg.ctrl[rtg_pkg::CTRL_WSEL +: 2];
  assign fake_pulse = s_reg.no_trig &&
                      (s_reg.fake_cnt == FKW'(FAKE_CYC - 1));
  // in external mode the pretrigger comes from the pin or the substitute
  assign pretrig = ext ? (ext_pulse | fake_pulse) : gstart[0];

  rtg_edge_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (first_trigger_connector_i),
    .fall_sel (s_reg.ctrl[rtg_pkg::CTRL_FALL]),
    .pulse    (ext_pulse)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_trig
      always_comb begin
        eff_p[g] = s_reg.period[g];
        if (s_reg.period[g] < s_reg.minp[wsel]) begin
          eff_p[g] = s_reg.minp[wsel];
        end else if (s_reg.period[g] > s_reg.maxp[wsel]) begin
          eff_p[g] = s_reg.maxp[wsel];
        end
      end
      rtg_gen #(.CW(CW)) u_gen (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .en       (en && !(g == 0 && ext)),
        .free_run (!ext),
        .sync     (g != 0 && ext && pretrig),
        .period   (eff_p[g]),
        .delay    (s_reg.gdelay[g]),
        .width    (s_reg.gwidth[g]),
        .pol      (s_reg.ctrl[rtg_pkg::CTRL_POL + g]),
        .trig     (gtrig[g]),
        .start    (gstart[g])
      );
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    idx = s_reg.aw_addr[3:2];
    ridx = araddr[3:2];
    val = '0;
    // write channel: address and data may arrive in either order
    if (awvalid && s_reg.awrdy) begin
      s_next.aw_addr = awaddr;
      s_next.awrdy = 1'b0;
    end
    if (wvalid && s_reg.wrdy) begin
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
      s_next.wrdy = 1'b0;
    end
    if (!s_reg.awrdy && !s_reg.wrdy && !s_reg.bvalid) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = rtg_pkg::RESP_OKAY;
      case (s_reg.aw_addr[7:4])
        rtg_pkg::GRP_CTL: begin
          if (s_reg.aw_addr == rtg_pkg::ADDR_CTRL) begin
            val = merge(32'(s_reg.ctrl), s_reg.w_data, s_reg.w_strb);
            s_next.ctrl = val[rtg_pkg::CTRL_W-1:0];
          end else if (s_reg.aw_addr == rtg_pkg::ADDR_RDELAY) begin
            val = merge(32'(s_reg.rdelay), s_reg.w_data, s_reg.w_strb);
            s_next.rdelay = val[CW-1:0];
          end else if (s_reg.aw_addr != rtg_pkg::ADDR_STATUS) begin
            s_next.bresp = rtg_pkg::RESP_SLVERR;
          end
        end
        rtg_pkg::GRP_PERIOD: begin
          val = merge(32'(s_reg.period[idx]), s_reg.w_data, s_reg.w_strb);
          s_next.period[idx] = val[CW-1:0];
        end
        rtg_pkg::GRP_GDELAY: begin
          val = merge(32'(s_reg.gdelay[idx]), s_reg.w_data, s_reg.w_strb);
          s_next.gdelay[idx] = val[CW-1:0];
        end
        rtg_pkg::GRP_GWIDTH: begin
          val = merge(32'(s_reg.gwidth[idx]), s_reg.w_data, s_reg.w_strb);
          s_next.gwidth[idx] = val[CW-1:0];
        end
        rtg_pkg::GRP_MINP: begin
          val = merge(32'(s_reg.minp[idx]), s_reg.w_data, s_reg.w_strb);
          s_next.minp[idx] = val[CW-1:0];
        end
        rtg_pkg::GRP_MAXP: begin
          val = merge(32'(s_reg.maxp[idx]), s_reg.w_data, s_reg.w_strb);
          s_next.maxp[idx] = val[CW-1:0];
        end
        default: begin
          s_next.bresp = rtg_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
      s_next.awrdy = 1'b1;
      s_next.wrdy = 1'b1;
    end
    if (arvalid && s_reg.arrdy) begin
      s_next.arrdy = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = rtg_pkg::RESP_OKAY;
      s_next.rdata = '0;
      case (araddr[7:4])
        rtg_pkg::GRP_CTL: begin
          if (araddr == rtg_pkg::ADDR_CTRL) begin
            s_next.rdata = 32'(s_reg.ctrl);
          end else if (araddr == rtg_pkg::ADDR_STATUS) begin
            s_next.rdata[rtg_pkg::ST_NOTRIG] = s_reg.no_trig;
            s_next.rdata[rtg_pkg::ST_BLANK] = s_reg.no_trig;
            s_next.rdata[rtg_pkg::ST_TRIG +: 4] = gtrig;
          end else if (araddr == rtg_pkg::ADDR_RDELAY) begin
            s_next.rdata = 32'(s_reg.rdelay);
          end else begin
            s_next.rresp = rtg_pkg::RESP_SLVERR;
          end
        end
        rtg_pkg::GRP_PERIOD: s_next.rdata = 32'(s_reg.period[ridx]);
        rtg_pkg::GRP_GDELAY: s_next.rdata = 32'(s_reg.gdelay[ridx]);
        rtg_pkg::GRP_GWIDTH: s_next.rdata = 32'(s_reg.gwidth[ridx]);
        rtg_pkg::GRP_MINP: s_next.rdata = 32'(s_reg.minp[ridx]);
        rtg_pkg::GRP_MAXP: s_next.rdata = 32'(s_reg.maxp[ridx]);
        default: s_next.rresp = rtg_pkg::RESP_SLVERR;
      endcase
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arrdy = 1'b1;
    end
    // missing pretrigger watchdog and substitute timer
    if (!en || !ext) begin
      s_next.wd = '0;
      s_next.no_trig = 1'b0;
      s_next.fake_cnt = '0;
    end else if (ext_pulse) begin
      s_next.wd = '0;
      s_next.no_trig = 1'b0;
      s_next.fake_cnt = '0;
    end else begin
      if (s_reg.wd != WDW'(WDOG_CYC)) begin
        s_next.wd = s_reg.wd + WDW'(1);
      end
      if (s_reg.wd == WDW'(WDOG_CYC - 1)) begin
        s_next.no_trig = 1'b1;
      end
      if (s_reg.no_trig) begin
        s_next.fake_cnt = fake_pulse ? '0 : s_reg.fake_cnt + FKW'(1);
      end
    end
    // range-zero timing restarts on every pretrigger
    s_next.range_zero = 1'b0;
    if (en && pretrig) begin
      s_next.rz_cnt = '0;
      s_next.rz_run = 1'b1;
    end else if (s_reg.rz_run) begin
      if (s_reg.rz_cnt == s_reg.rdelay) begin
        s_next.range_zero = 1'b1;
        s_next.rz_run = 1'b0;
      end else begin
        s_next.rz_cnt = s_reg.rz_cnt + CW'(1);
      end
    end
    // the connector is released one cycle after external mode is selected, so a fight with the source lasts one cycle at most
    s_next.oe = en && !ext;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awrdy <= 1'b1;
      s_reg.wrdy <= 1'b1;
      s_reg.arrdy <= 1'b1;
      for (int i = 0; i < 4; i++) begin
        s_reg.period[i] <= rtg_pkg::PERIOD_RST;
        s_reg.gwidth[i] <= rtg_pkg::GWIDTH_RST;
        s_reg.minp[i] <= CW'(rtg_pkg::MIN_PERIOD_CYC);
        s_reg.maxp[i] <= CW'(rtg_pkg::MAX_PERIOD_CYC);
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awrdy;
  assign wready = s_reg.wrdy;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arrdy;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign first_trigger_connector_o = gtrig[0];
  assign first_trigger_connector_oe = s_reg.oe;
  assign trigger_out_two = gtrig[1];
  assign trigger_out_three = gtrig[2];
  assign trigger_out_four = gtrig[3];
  assign range_zero = s_reg.range_zero;
  assign no_trigger = s_reg.no_trig;
  assign data_blank = s_reg.no_trig;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped before bready");
  rvalid_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer changed before rready");
  conn_input_a: assert property (
    ext |=> !first_trigger_connector_oe)
    else $error("connector driven in external mode");
  wdog_fire_a: assert property (
    $rose(no_trigger) |-> $past(s_reg.wd) == WDW'(WDOG_CYC - 1))
    else $error("no-trigger raised at wrong count");
  wdog_clear_a: assert property (
    en && ext && ext_pulse |=> s_reg.wd == '0 && !no_trigger)
    else $error("watchdog not cleared by edge");
  resume_ext_a: assert property (
    no_trigger && ext_pulse && en && ext |=> !no_trigger && !data_blank)
    else $error("substitute mode did not end");
  single_pulse_a: assert property (ext_pulse |=> !ext_pulse)
    else $error("edge pulse longer than one cycle");
  rz_delay_a: assert property (
    range_zero |-> $past(s_reg.rz_cnt) == s_reg.rdelay &&
                   !$past(range_zero))
    else $error("range zero at wrong delay");
  rz_restart_a: assert property (
    en && pretrig |=> s_reg.rz_run && s_reg.rz_cnt == '0)
    else $error("range timing not restarted");
  resync_gen_a: assert property (
    en && ext && pretrig |=> gstart[1] && gstart[3])
    else $error("outputs not resynchronised");
  period_clamp_a: assert property (
    s_reg.minp[wsel] <= s_reg.maxp[wsel] |->
      eff_p[2] >= s_reg.minp[wsel] && eff_p[2] <= s_reg.maxp[wsel])
    else $error("period outside width limits");

  fake_seen_c: cover property (en && ext && fake_pulse);
  resume_seen_c: cover property (no_trigger ##1 !no_trigger && ext);
  rz_seen_c: cover property (range_zero && ext);
  wr_seen_c: cover property (bvalid && bready);
endmodule

// file: rtg_radar_model.sv
`timescale 1ns/1ps
// far side: existing trigger distribution driving the pretrigger line
module rtg_radar_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       attach,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  input  wire logic       active_low,
  output logic            pin_drive,
  output logic            pin_en
);
  logic [7:0] left_reg;

  // pulse length is arbitrary on purpose: only the chosen edge carries timing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg  <= 8'h00;
      pin_drive <= active_low;
    end else if (fire) begin
      left_reg  <= width;
      pin_drive <= ~active_low;
    end else begin
      left_reg  <= (left_reg != 8'h00) ? left_reg - 8'h01 : 8'h00;
      pin_drive <= (left_reg > 8'h01) ? ~active_low : active_low;
    end
  end

  // the line is only driven once cabled in; otherwise the pull-down holds it
  assign pin_en = attach;
endmodule

// file: radar_trigger_generator_tb_top.sv
`timescale 1ns/1ps
module radar_trigger_generator_tb_top;
  localparam int WD = 200;
  localparam int FK = 40;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, width;
  logic [31:0] wdata, d;
  logic [31:0] rdata;
  logic [3:0]  wstrb, pol;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pin, pin_o, pin_oe, t2, t3, t4, rz, blank, notrig;
  logic        attach, fire, act_low, m_drv, m_en;
  int          errors, compares, seed, rz_cnt, i, g, k, n, c0, rdl;
  int          per_set [4];
  int          gw [4];
  int          mp, mw, offs [3], nrz;
  logic [7:0]  ra [8] = '{8'h00, 8'h08, 8'h10, 8'h1c, 8'h20, 8'h30, 8'h40,
                          8'h5c};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h4e20, 32'h4e20, 32'h0, 32'h14,
                          32'h3e8, 32'h61a80};

  // connector resolves between the block, the far side and a pull-down
  assign pin = pin_oe ? pin_o : (m_en ? m_drv : 1'b0);

  rtg_top #(.WDOG_CYC(WD), .FAKE_CYC(FK)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .first_trigger_connector_i(pin), .first_trigger_connector_o(pin_o),
    .first_trigger_connector_oe(pin_oe), .trigger_out_two(t2),
    .trigger_out_three(t3), .trigger_out_four(t4), .range_zero(rz),
    .data_blank(blank), .no_trigger(notrig));

  rtg_radar_model far_end (
    .aclk(aclk), .aresetn(aresetn), .attach(attach), .fire(fire),
    .width(width), .active_low(act_low), .pin_drive(m_drv), .pin_en(m_en));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) if (rz) rz_cnt <= rz_cnt + 1;

  task automatic end_of_test();
    $display("counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tmo(input string nm);
    errors++;
    $display("wrong value %s expected done seen timeout", nm);
    end_of_test();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    int j;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (j == 50) tmo("write response");
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    int j;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (j == 50) tmo("read response");
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic gout(input int x);
    case (x)
      0: return pin_o;
      1: return t2;
      2: return t3;
      default: return t4;
    endcase
  endfunction

  function automatic int clampp(input int p, input int mn, input int mx);
    int t;
    t = (p > mx) ? mx : p;
    return (t < mn) ? mn : t;
  endfunction

  // period from one active edge to the next, width in active samples
  task automatic meas(input int x, input logic pl, output int per,
                      output int wid);
    int ph, j;
    logic prv, cur;
    per = 0;
    wid = 0;
    ph = 0;
    prv = 1'b1;
    for (j = 0; j < 6000; j++) begin
      @(posedge aclk);
      cur = gout(x) ^ pl;
      if (cur && !prv && ph == 2) break;
      if (cur && !prv && ph == 0) ph = 1;
      if (ph != 0) per++;
      if (ph == 1 && cur) wid++;
      if (ph == 1 && !cur) ph = 2;
      prv = cur;
    end
    if (j == 6000) tmo("generator period");
  endtask

  task automatic ext_pulse(input logic [7:0] w, output int nr,
                           output int nt);
    int j, c;
    c = rz_cnt;
    @(posedge aclk);
    width <= w;
    fire <= 1'b1;
    nr = 0;
    nt = 0;
    for (j = 1; j < 250; j++) begin
      @(posedge aclk);
      fire <= 1'b0;
      if (rz && nr == 0) nr = j;
      if ((t2 ^ pol[1]) && nt == 0) nt = j;
      if (j > w + 60 && nr != 0) break;
    end
    chk("range zero count", 1, rz_cnt - c);
    chk("generator two restarted", 1, nt != 0);
  endtask

  initial begin
    seed = 32'h599a54d0;
    {errors, compares, rz_cnt} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {attach, fire, act_low} = '0;
    {awaddr, araddr, wdata} = '0;
    width = 8'h04;
    wstrb = 4'hf;
    pol = 4'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(ra[i], d, r);
      chk("reset value", rv[i], d);
    end
    rd(8'hfc, d, r);
    chk("unmapped read resp", rtg_pkg::RESP_SLVERR, r);
    chk("unmapped read data", 32'h0, d);
    wr(8'hfc, 32'hffffffff, r);
    chk("unmapped write resp", rtg_pkg::RESP_SLVERR, r);
    wr(8'h04, 32'hffffffff, r);
    rd(8'h04, d, r);
    chk("status read only", 32'h0, d & 32'h3);
    d = $random(seed);
    wr(8'h08, d, r);
    rdl = d & 32'hfffff;
    rd(8'h08, d, r);
    chk("range delay field", rdl, d);
    wstrb <= 4'h2;
    wr(8'h08, 32'hffffffff, r);
    wstrb <= 4'hf;
    rd(8'h08, d, r);
    chk("byte strobe merge", rdl | 32'hff00, d);
    $display("test registers done");

    wr(8'h40, 32'd64, r);
    wr(8'h50, 32'd300, r);
    per_set = '{10, 1000, {$random(seed)} % 381 + 20,
                {$random(seed)} % 381 + 20};
    for (g = 0; g < 4; g++) begin
      gw[g] = {$random(seed)} % 12 + 1;
      wr(8'h10 + 8'(4 * g), per_set[g], r);
      wr(8'h20 + 8'(4 * g), {$random(seed)} % 8, r);
      wr(8'h30 + 8'(4 * g), gw[g], r);
    end
    pol = $random(seed);
    for (k = 0; k < 2; k++) begin
      wr(8'h00, {20'h0, pol, 2'h0, 2'(k), 4'h1}, r);
      @(posedge aclk);
      chk("connector driven", 1'b1, pin_oe);
      for (g = 0; g < 4; g++) begin
        meas(g, pol[g], mp, mw);
        chk("period", k == 0 ? clampp(per_set[g], 64, 300) :
            clampp(per_set[g], 1000, 400000), mp);
        chk("pulse width", gw[g], mw);
      end
    end
    $display("test internal generators done");

    attach <= 1'b1;
    for (k = 0; k < 2; k++) begin
      act_low <= k[0];
      rdl = {$random(seed)} % 31;
      if (k == 0) rdl = 0;
      wr(8'h08, rdl, r);
      wr(8'h00, {20'h0, pol, 5'h0, k[0], 2'h3}, r);
      // edges left in the synchroniser by the mode switch must run out
      repeat (40) @(posedge aclk);
      chk("connector released", 1'b0, pin_oe);
      for (i = 0; i < 3; i++) begin
        ext_pulse({$random(seed)} % 60 + 1, nrz, offs[i]);
        chk("range zero delay", rdl + 7, nrz);
        chk("resync offset", offs[0], offs[i]);
        repeat ({$random(seed)} % 40) @(posedge aclk);
      end
    end
    $display("test external pretrigger done");

    ext_pulse(8'h08, nrz, offs[0]);
    for (n = 0; n < WD + 20 && !notrig; n++) @(posedge aclk);
    chk("watchdog expiry", 1, n >= WD - 90 && n <= WD - 60);
    rd(8'h04, d, r);
    chk("status flags", 2'h3, d[1:0]);
    chk("data blank", 1'b1, blank);
    c0 = -1;
    mp = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (rz && c0 >= 0) begin
        mp = i - c0;
        break;
      end
      if (rz) c0 = i;
    end
    chk("substitute period", FK, mp);
    @(posedge aclk);
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    for (n = 0; n < 20 && notrig; n++) @(posedge aclk);
    chk("no trigger cleared", 1'b0, notrig);
    $display("test missing trigger done");
    end_of_test();
  end
endmodule
